// ### design/dzs_pkg.sv
/*
 * Shared constants and carrier types for the distance zone sequencer.
 * Assumes a single 250 MHz clock and that every pin input is
 * synchronised inside the top module before use.
 */
// Summary of operation
// - Standby pin low clears the phase, judged zone, output zone and valid state.
// - Quick charge between first two falling edges.
// - Ambient hold from a rising edge to the next falling edge.
// - Zone decided at falling edge after hold.
// - Zone code output at next rising edge.
// - Measurements repeat without new quick charge.
// - Ratio of two currents classified into four zones.
// - No reflected signal reports the nearest zone.
// - Codes: LL near, HL, LH, HH far.
package dzs_pkg;

   // Width of the ratio word presented by the analog front end.
   localparam int RATIO_W = 8;

   // Stabilisation time the host must respect after quick charge.
   localparam int STAB_TIME_US = 1000;
   localparam int CLK_MHZ = 250;
   // Cycle count of the stabilisation time, for reference by the bench.
   localparam int STAB_CYCLES = STAB_TIME_US * CLK_MHZ;

   // Reset values of the zone outputs.
   localparam logic [1:0] ZONE_RST = 2'h0;

   // Zone codes, bit0 is the first output and bit1 the second.
   localparam logic [1:0] ZONE_NEAR = 2'h0;
   localparam logic [1:0] ZONE_2 = 2'h1;
   localparam logic [1:0] ZONE_3 = 2'h2;
   localparam logic [1:0] ZONE_FAR = 2'h3;

   // Default zone boundaries on the ratio word.
   localparam logic [7:0] THR1_RST = 8'h40;
   localparam logic [7:0] THR2_RST = 8'h80;
   localparam logic [7:0] THR3_RST = 8'hC0;

   // Sequencer phases, one-hot.
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01, // Waiting for the first falling edge.
      ST_QCHG = 5'h02, // Quick charging the hold capacitor.
      ST_ARM = 5'h04, // Waiting for a rising edge to start holding.
      ST_HOLD = 5'h08, // Holding the ambient level.
      ST_JUDGED = 5'h10 // Decision taken, output on next rising edge.
   } dzs_state_t;

   // Samples handed from the front end to the classifier.
   typedef struct packed {
      logic signal_ok; // High when reflected light was received.
      logic [RATIO_W-1:0] ratio; // Scaled I1/(I1+I2).
   } dzs_meas_t;

   // Zone boundaries, ascending.
   typedef struct packed {
      logic [RATIO_W-1:0] t1;
      logic [RATIO_W-1:0] t2;
      logic [RATIO_W-1:0] t3;
   } dzs_thr_t;

endpackage : dzs_pkg

// ### design/dzs_top.sv
/*
 * Distance zone sequencer: steps through quick charge, ambient hold,
 * judgement and output on edges of the sequence pulse pin.
 * Assumes pins are asynchronous to clk, and the analog front end
 * supplies a settled measurement word on the same clock.
 */
`timescale 1ns/10ps
module dzs_top (
   input wire logic clk, // 250 MHz clock.
   input wire logic rst_b, // Asynchronous reset, active low.
   input wire logic standby_reset_pin, // Low holds device in reset.
   input wire logic sequence_pulse_input, // Host control pulse pin.
   input wire dzs_pkg::dzs_meas_t meas, // Front end measurement.
   input wire dzs_pkg::dzs_thr_t thr, // Zone boundaries.
   output logic quick_charge, // Quick charge switch on.
   output logic ambient_hold, // Ambient hold switch on.
   output logic zone_code_bit0_i, // Open-collector input side.
   output logic zone_code_bit0_o, // Open-collector drive level.
   output logic zone_code_bit0_oe, // High when pulling low.
   output logic zone_code_bit1_o, // Open-collector drive level.
   output logic zone_code_bit1_oe, // High when pulling low.
   output logic zone_valid // A zone has been output.
);

   // Reset release synchroniser.
   logic rst_s1_ff;
   logic rst_s2_ff;
   // Pin synchronisers; first stages feed only second stages.
   logic stb_s1_ff;
   logic stb_s2_ff;
   logic pls_s1_ff;
   logic pls_s2_ff;
   logic pls_d_ff; // Previous synced pulse level.
   dzs_pkg::dzs_state_t state_ff;
   dzs_pkg::dzs_state_t nxt_state;
   logic [1:0] zone_ff; // Zone shown on the pins.
   logic [1:0] nxt_zone;
   logic [1:0] judged_ff; // Zone held from the decision.
   logic [1:0] nxt_judged;
   logic valid_ff;
   logic nxt_valid;
   logic [1:0] class_zone;

   // Release reset cleanly into the clock domain.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_ff <= 1'h0;
         rst_s2_ff <= 1'h0;
      end else begin
         rst_s1_ff <= 1'h1;
         rst_s2_ff <= rst_s1_ff;
      end
   end
   wire rst_i_b = rst_s2_ff;

   // Two flops on each pin before any logic looks at it.
   always_ff @(posedge clk or negedge rst_i_b) begin
      if (!rst_i_b) begin
         stb_s1_ff <= 1'h0;
         stb_s2_ff <= 1'h0;
         pls_s1_ff <= 1'h0;
         pls_s2_ff <= 1'h0;
         pls_d_ff <= 1'h0;
      end else begin
         stb_s1_ff <= standby_reset_pin;
         stb_s2_ff <= stb_s1_ff;
         pls_s1_ff <= sequence_pulse_input;
         pls_s2_ff <= pls_s1_ff;
         pls_d_ff <= pls_s2_ff;
      end
   end

   // Edge detection on the synchronised pulse.
   wire rise = pls_s2_ff & ~pls_d_ff;
   wire fall = ~pls_s2_ff & pls_d_ff;
   // Standby low acts as a synchronous clear of the phase, judged zone, output zone and valid registers.
   wire standby = ~stb_s2_ff;

   // Zone decision from the current measurement.
   dzs_zone_classify u_class (
      .meas(meas),
      .thr(thr),
      .zone(class_zone)
   );

   // Phase sequencing and output update.
   always_comb begin
      nxt_state = state_ff;
      nxt_zone = zone_ff;
      nxt_judged = judged_ff;
      nxt_valid = valid_ff;
      if (standby) begin
         nxt_state = dzs_pkg::ST_IDLE;
         nxt_zone = dzs_pkg::ZONE_RST;
         nxt_judged = dzs_pkg::ZONE_RST;
         nxt_valid = 1'h0;
      end else begin
         unique case (state_ff)
            dzs_pkg::ST_IDLE: begin
               if (fall) begin
                  nxt_state = dzs_pkg::ST_QCHG;
               end
            end
            dzs_pkg::ST_QCHG: begin
               if (fall) begin
                  nxt_state = dzs_pkg::ST_ARM;
               end
            end
            dzs_pkg::ST_ARM: begin
               if (rise) begin
                  nxt_state = dzs_pkg::ST_HOLD;
               end
            end
            dzs_pkg::ST_HOLD: begin
               // hold ends falling and judges; a rise goes back to ST_ARM.
               if (rise) begin
                  nxt_state = dzs_pkg::ST_ARM;
               end else if (fall) begin
                  nxt_judged = class_zone;
                  nxt_state = dzs_pkg::ST_JUDGED;
               end
            end
            dzs_pkg::ST_JUDGED: begin
               if (rise) begin
                  nxt_zone = judged_ff;
                  nxt_valid = 1'h1;
                  nxt_state = dzs_pkg::ST_HOLD;
               end
            end
            default: begin
               nxt_state = dzs_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // State registers.
   always_ff @(posedge clk or negedge rst_i_b) begin
      if (!rst_i_b) begin
         state_ff <= dzs_pkg::ST_IDLE;
         zone_ff <= dzs_pkg::ZONE_RST;
         judged_ff <= dzs_pkg::ZONE_RST;
         valid_ff <= 1'h0;
      end else begin
         state_ff <= nxt_state;
         zone_ff <= nxt_zone;
         judged_ff <= nxt_judged;
         valid_ff <= nxt_valid;
      end
   end

   // Phase indications for the analog switches.
   assign quick_charge = (state_ff == dzs_pkg::ST_QCHG);
   assign ambient_hold = (state_ff == dzs_pkg::ST_HOLD);
   assign zone_valid = valid_ff;
   // open-collector encoding
   // Pin pulled low when the code bit is low, released when high.
   assign zone_code_bit0_i = zone_ff[0];
   assign zone_code_bit0_o = 1'h0;
   assign zone_code_bit0_oe = ~zone_ff[0];
   assign zone_code_bit1_o = 1'h0;
   assign zone_code_bit1_oe = ~zone_ff[1];

endmodule : dzs_top

// ### design/dzs_zone_classify.sv
/*
 * Combinational zone classifier.
 * Assumes boundaries are ascending and the measurement is stable
 * while the sequencer samples the result.
 */
`timescale 1ns/10ps
module dzs_zone_classify (
   input wire dzs_pkg::dzs_meas_t meas, // Ratio and signal flag.
   input wire dzs_pkg::dzs_thr_t thr, // Zone boundaries.
   output logic [1:0] zone // Encoded zone.
);

   // Compare results against each boundary.
   wire ge1 = meas.ratio >= thr.t1;
   wire ge2 = meas.ratio >= thr.t2;
   wire ge3 = meas.ratio >= thr.t3;

   // Pick the zone; no signal falls back to near.
   always_comb begin
      if (!meas.signal_ok) begin
         zone = dzs_pkg::ZONE_NEAR;
      end else if (ge3) begin
         zone = dzs_pkg::ZONE_FAR;
      end else if (ge2) begin
         zone = dzs_pkg::ZONE_3;
      end else if (ge1) begin
         zone = dzs_pkg::ZONE_2;
      end else begin
         zone = dzs_pkg::ZONE_NEAR;
      end
   end

endmodule : dzs_zone_classify

// ### dv/dzs_host_model.sv
/* Host model: drives the standby pin, the pulse pin and the emitter.
   Assumes one bench process calls its tasks. */
`timescale 1ns/10ps
module dzs_host_model #(
   parameter int STAB = 40 // Settling wait, shortened.
) (
   input wire logic clk, // Bench clock.
   output logic standby_reset_pin, // Low clears.
   output logic sequence_pulse_input, // Pulse pin.
   output logic infrared_emitter // Emitter drive.
);
   logic armed = 1'b0; // Charge done.
   initial begin
      standby_reset_pin = 1'b0;
      sequence_pulse_input = 1'b1;
      infrared_emitter = 1'b0;
   end
   task automatic set_standby(input logic v);
      @(negedge clk) standby_reset_pin = v;
      armed = 1'b0;
      repeat (8) @(posedge clk);
   endtask : set_standby
   // Wide spacing keeps every edge visible.
   task automatic edge_to(input logic v);
      @(negedge clk) sequence_pulse_input = v;
      infrared_emitter = v & armed;
      repeat (8) @(posedge clk);
   endtask : edge_to
   task automatic settle();
      repeat (STAB) @(posedge clk);
      armed = 1'b1;
   endtask : settle
endmodule : dzs_host_model

// ### dv/dzs_top_asserts.sv
/* Port checker for the zone sequencer.
   Assumes pin edges at least eight clocks apart. */
`timescale 1ns/10ps
module dzs_top_asserts (
   input wire logic clk, // Clock.
   input wire logic rst_b, // Reset.
   input wire logic standby_reset_pin, // Standby.
   input wire logic sequence_pulse_input, // Pulse.
   input wire logic quick_charge, // Charge.
   input wire logic ambient_hold, // Hold.
   input wire logic zone_code_bit0_i, // Bit0.
   input wire logic zone_code_bit0_o, // Drive 0.
   input wire logic zone_code_bit0_oe, // Pull 0.
   input wire logic zone_code_bit1_o, // Drive 1.
   input wire logic zone_code_bit1_oe, // Pull 1.
   input wire logic zone_valid // Shown.
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // Standby level that has passed the synchroniser.
   sequence s_awake;
      standby_reset_pin [*5];
   endsequence
   sequence s_asleep;
      !standby_reset_pin [*5];
   endsequence
   chk_reset_clear:
      assert property ($rose(rst_b) |-> !zone_valid && !quick_charge
         && zone_code_bit0_oe && zone_code_bit1_oe) else $error("reset");
   chk_standby_clear:
      assert property (s_asleep |-> !zone_valid && !ambient_hold
         && zone_code_bit0_oe && zone_code_bit1_oe) else $error("stb");
   chk_phase_excl:
      assert property (!(quick_charge && ambient_hold)) else $error("ph");
   chk_charge_cause:
      assert property ($rose(quick_charge) |-> !sequence_pulse_input
         && $past(sequence_pulse_input, 2) == 1'b0) else $error("qc");
   chk_hold_cause:
      assert property ($rose(ambient_hold) |-> sequence_pulse_input
         && $past(sequence_pulse_input, 2)) else $error("hold");
   chk_output_rise:
      assert property ($rose(zone_valid) |-> ambient_hold
         && sequence_pulse_input) else $error("out");
   chk_code_stable:
      assert property ($changed({zone_code_bit1_oe, zone_code_bit0_oe})
         |-> !zone_valid || ambient_hold) else $error("code");
   chk_valid_holds:
      assert property (s_awake ##0 zone_valid |=> zone_valid)
      else $error("valid");
   chk_open_drain:
      assert property (!zone_code_bit0_o && !zone_code_bit1_o
         && zone_code_bit0_oe == !zone_code_bit0_i) else $error("od");
endmodule : dzs_top_asserts
bind dzs_top dzs_top_asserts u_chk (.*);

// ### dv/tb_dzs_top.sv
/* Bench: random measurements judged through the host model.
   Assumes pulled-up pins; default zone bounds first, then random ones. */
`timescale 1ns/10ps
module tb_dzs_top;
   logic clk = 1'b0, rst_b = 1'b0;
   logic standby_reset_pin, sequence_pulse_input, infrared_emitter;
   logic quick_charge, ambient_hold, zone_code_bit0_i, zone_code_bit0_o;
   logic zone_code_bit0_oe, zone_code_bit1_o, zone_code_bit1_oe;
   logic zone_valid;
   logic [1:0] code, want;
   logic [31:0] lfsr = 32'h9D964906;
   dzs_pkg::dzs_meas_t meas = '0, m;
   dzs_pkg::dzs_thr_t thr;
   int err_count = 0, cmp_count = 0;
   // Open-collector pins with pull-ups.
   assign code = {~zone_code_bit1_oe, ~zone_code_bit0_oe};
   always #2 clk = ~clk;
   dzs_top dut (.*);
   dzs_host_model host (.clk(clk), .standby_reset_pin(standby_reset_pin),
      .sequence_pulse_input(sequence_pulse_input),
      .infrared_emitter(infrared_emitter));
   function automatic logic [31:0] nxt_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt_rand
   function automatic logic [1:0] exp_zone(input dzs_pkg::dzs_meas_t x);
      if (!x.signal_ok) return dzs_pkg::ZONE_NEAR;
      if (x.ratio >= thr.t3) return dzs_pkg::ZONE_FAR;
      if (x.ratio >= thr.t2) return dzs_pkg::ZONE_3;
      if (x.ratio >= thr.t1) return dzs_pkg::ZONE_2;
      return dzs_pkg::ZONE_NEAR;
   endfunction : exp_zone
   // Corners first, then random words.
   function automatic dzs_pkg::dzs_meas_t pick(int i, logic [31:0] s);
      case (i)
         0: return {1'b0, 8'hFF};
         1: return {1'b1, thr.t1 - 8'h01};
         2: return {1'b1, thr.t1};
         3: return {1'b1, thr.t3};
         default: return {s[8] | s[9], s[7:0]};
      endcase
   endfunction : pick
   // Three bits wide so that a flag and a two-bit code compare together.
   task automatic check(input logic [2:0] seen, input logic [2:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t seen %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report();
      $display("Compares %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   initial begin
      #100000;
      err_count++;
      final_report();
   end
   initial begin
      repeat (10) @(posedge clk);
      @(negedge clk) rst_b = 1'b1;
      for (int r = 0; r < 2; r++) begin
         want = dzs_pkg::ZONE_RST;
         // First round uses the default bounds, later rounds random ones.
         lfsr = nxt_rand(lfsr);
         @(negedge clk);
         if (r == 0) begin
            thr = {dzs_pkg::THR1_RST, dzs_pkg::THR2_RST, dzs_pkg::THR3_RST};
         end else begin
            thr.t1 = {2'h0, lfsr[5:0]} + 8'h10;
            thr.t2 = thr.t1 + 8'h40;
            thr.t3 = thr.t2 + 8'h40;
         end
         host.set_standby(1'b1);
         host.edge_to(1'b0);
         check(quick_charge, 1'b1);
         host.edge_to(1'b1);
         check(quick_charge, 1'b1);
         host.edge_to(1'b0);
         check(quick_charge, 1'b0);
         host.settle();
         host.edge_to(1'b1);
         check(ambient_hold, 1'b1);
         for (int i = 0; i < 16; i++) begin
            lfsr = nxt_rand(lfsr);
            m = pick(i, lfsr);
            @(negedge clk) meas = m;
            host.edge_to(1'b0);
            check(ambient_hold, 1'b0);
            check(infrared_emitter, 1'b0);
            check(code, want);
            @(negedge clk) meas = ~m;
            host.edge_to(1'b1);
            want = exp_zone(m);
            check(code, want);
            check(zone_code_bit0_i, want[0]);
            check({zone_valid, ambient_hold}, 2'h3);
            check(infrared_emitter, ambient_hold);
         end
         host.set_standby(1'b0);
         check({zone_valid, code}, 3'h0);
      end
      final_report();
   end
endmodule : tb_dzs_top
